// [pss_map.svh]
`ifndef PSS_MAP_SVH
`define PSS_MAP_SVH
// Register byte offsets
`define PSS_REG_CTRL 8'h00
`define PSS_REG_CMD 8'h04
`define PSS_REG_STATUS 8'h08
`define PSS_REG_XFER_IDX 8'h0C
`define PSS_REG_XFER_DATA 8'h10
`define PSS_REG_LIVE_IDX 8'h14
`define PSS_REG_LIVE_DATA 8'h18
// Control field positions
`define PSS_CTRL_SLOT_LSB 0
`define PSS_CTRL_KEEPIF_BIT 2
`define PSS_CTRL_XSEL_BIT 3
`define PSS_CTRL_MATONLY_BIT 4
`define PSS_CTRL_IFKEEP_BIT 5
// Command bits
`define PSS_CMD_ACTIVATE_BIT 0
`define PSS_CMD_SAVE_BIT 1
`define PSS_CMD_EXPORT_BIT 2
`define PSS_CMD_IMPORT_BIT 3
`define PSS_CMD_RESTORE_BIT 4
// Status field positions
`define PSS_STAT_BUSY_BIT 0
`define PSS_STAT_REFUSED_BIT 1
`define PSS_STAT_LAST_LSB 2
// Reset values and sizes
`define PSS_SLOT_RST 2'h1
`define PSS_SLOT_MAX 3
`define PSS_SET_WORDS 8
`define PSS_MAT_WORDS 8
`define PSS_IF_WORDS 2
// Nonvolatile memory word map
`define PSS_NVM_SLOT_STRIDE 16'h0040
`define PSS_NVM_MAT_BASE 16'h0100
`define PSS_NVM_FAC_SET 16'h0200
`define PSS_NVM_FAC_MAT 16'h0240
`define PSS_NVM_PTR_ADDR 16'h0300
`endif

// [pss_nvm_model.sv]
`timescale 1ns/1ps
module pss_nvm_model (
  input wire logic ref_clk, // System clock
  input wire logic sys_rst, // Async reset, active high
  input wire logic slowMem, // Stretch the next answer
  input wire pss_pkg::pss_nvm_req_t nvmReq, // Memory request
  output pss_pkg::pss_nvm_rsp_t nvmRsp // Memory answer
);
  import pss_pkg::*;
  logic [31:0] mem [0:1023];
  logic [1:0] waitCnt;
  // Slots, materials, factory image and boot pointer; contents survive reset
  initial begin
    for (int i = 0; i < 1024; i++) begin
      mem[i] = 32'h5A000000 | i;
    end
    mem[10'h300] = 32'h00000002; // Last saved slot
  end
  // One ack per request, prompt or stretched; stale read data toggles
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      nvmRsp <= '0;
      waitCnt <= 2'h0;
    end else begin
      nvmRsp.ack <= 1'b0;
      nvmRsp.rdata <= ~nvmRsp.rdata;
      if (nvmReq.req && !nvmRsp.ack) begin
        if (waitCnt != 2'h0) begin
          waitCnt <= waitCnt - 2'h1;
        end else begin
          nvmRsp.ack <= 1'b1;
          waitCnt <= slowMem ? 2'h3 : 2'h0;
          if (nvmReq.we) begin
            mem[nvmReq.addr[9:0]] <= nvmReq.wdata; // Stored word
          end else begin
            nvmRsp.rdata <= mem[nvmReq.addr[9:0]]; // Read word
          end
        end
      end
    end
  end
endmodule

// [pss_parameter_set_store.sv]
`timescale 1ns/1ps
`include "pss_map.svh"
module pss_parameter_set_store #(
  parameter int SET_WORDS = `PSS_SET_WORDS,
  parameter int MAT_WORDS = `PSS_MAT_WORDS,
  parameter int IF_WORDS = `PSS_IF_WORDS
) (
  input wire logic ref_clk, // System clock, 40 MHz
  input wire logic sys_rst, // Async reset, active high
  input wire pss_pkg::pss_avs_req_t avs, // Avalon request
  output logic [31:0] readdata, // Avalon read data
  output logic waitrequest, // Avalon wait
  output pss_pkg::pss_nvm_req_t nvmReq, // Memory request
  input wire pss_pkg::pss_nvm_rsp_t nvmRsp, // Memory answer
  output logic busy // Operation running
);
  import pss_pkg::*;

  localparam int BUF_WORDS = (SET_WORDS > MAT_WORDS) ? SET_WORDS : MAT_WORDS;
  localparam int IDXW = $clog2(BUF_WORDS);
  localparam int LIVW = $clog2(SET_WORDS);

  // Refuse sizes the logic cannot serve
  if (SET_WORDS < 2 || MAT_WORDS < 2 || IF_WORDS < 1 || IF_WORDS >= SET_WORDS || BUF_WORDS > 32) begin : g_chk
    $error("pss_parameter_set_store: unsupported word counts");
  end

  typedef struct packed {
    pss_state_e st;
    logic [1:0] slot;
    logic keepIf;
    logic xferSel;
    logic matOnly;
    logic ifKeep;
    logic [1:0] lastSlot;
    logic refused;
    logic keepNow;
    logic thenMat;
    logic [15:0] base;
    logic [15:0] matSrc;
    logic [1:0] opSlot; // Slot latched when a save starts
    logic [IDXW-1:0] idx;
    logic [SET_WORDS-1:0][31:0] liveSet;
    logic [MAT_WORDS-1:0][31:0] liveMat;
    logic [BUF_WORDS-1:0][31:0] xbuf;
    logic [IDXW-1:0] xIdx;
    logic [LIVW-1:0] lIdx;
    logic ack;
    logic [31:0] rdata;
    pss_nvm_req_t nvm;
  } pss_core_t;

  pss_core_t s;
  pss_core_t n;
  logic rdDone;
  logic wrDone;
  logic [7:0] regOff;
  logic [4:0] cmd;
  logic slotOk;
  logic step;
  logic lastSet;
  logic lastMat;

  // Word base of a slot in memory
  function automatic logic [15:0] slotBase(input logic [1:0] sl);
    slotBase = 16'(sl) * `PSS_NVM_SLOT_STRIDE;
  endfunction

  assign readdata = s.rdata;
  assign nvmReq = s.nvm;
  assign busy = (s.st != ST_IDLE);
  assign waitrequest = (avs.read | avs.write) & ~s.ack;

  // Next-state logic
  always_comb begin
    n = s;
    regOff = {avs.address[7:2], 2'b00};
    rdDone = avs.read & s.ack;
    wrDone = avs.write & s.ack;
    cmd = avs.writedata[4:0];
    slotOk = (s.slot != 2'h0) && (32'(s.slot) <= `PSS_SLOT_MAX);
    step = s.nvm.req & nvmRsp.ack;
    lastSet = (32'(s.idx) == SET_WORDS - 1);
    lastMat = (32'(s.idx) == MAT_WORDS - 1);
    // One-wait-state bus answer
    n.ack = (avs.read | avs.write) & ~s.ack;
    n.rdata = 32'h00000000;
    case (regOff)
      `PSS_REG_CTRL: n.rdata = {26'h0, s.ifKeep, s.matOnly, s.xferSel, s.keepIf, s.slot};
      `PSS_REG_STATUS: n.rdata = {28'h0, s.lastSlot, s.refused, busy};
      `PSS_REG_XFER_IDX: n.rdata = 32'(s.xIdx);
      `PSS_REG_XFER_DATA: n.rdata = s.xbuf[s.xIdx];
      `PSS_REG_LIVE_IDX: n.rdata = 32'(s.lIdx);
      `PSS_REG_LIVE_DATA: n.rdata = s.liveSet[s.lIdx];
      default: n.rdata = 32'h00000000;
    endcase
    // Read of the transfer window walks the image
    if (rdDone && regOff == `PSS_REG_XFER_DATA) begin
      n.xIdx = (32'(s.xIdx) == BUF_WORDS - 1) ? '0 : s.xIdx + 1'b1;
    end
    // Register writes
    if (wrDone) begin
      case (regOff)
        `PSS_REG_CTRL: begin
          n.slot = avs.writedata[`PSS_CTRL_SLOT_LSB +: 2];
          n.keepIf = avs.writedata[`PSS_CTRL_KEEPIF_BIT];
          n.xferSel = avs.writedata[`PSS_CTRL_XSEL_BIT];
          n.matOnly = avs.writedata[`PSS_CTRL_MATONLY_BIT];
          n.ifKeep = avs.writedata[`PSS_CTRL_IFKEEP_BIT];
        end
        `PSS_REG_XFER_IDX: n.xIdx = avs.writedata[IDXW-1:0];
        `PSS_REG_XFER_DATA: begin
          // Import data only fills the buffer
          n.xbuf[s.xIdx] = avs.writedata;
          n.xIdx = (32'(s.xIdx) == BUF_WORDS - 1) ? '0 : s.xIdx + 1'b1;
        end
        `PSS_REG_LIVE_IDX: n.lIdx = avs.writedata[LIVW-1:0];
        `PSS_REG_LIVE_DATA: begin
          if (!busy) begin
            n.liveSet[s.lIdx] = avs.writedata;
            n.lIdx = (32'(s.lIdx) == SET_WORDS - 1) ? '0 : s.lIdx + 1'b1;
          end
        end
        `PSS_REG_CMD: begin
          n.refused = 1'b0;
          if (cmd == 5'h00) begin
            n.refused = s.refused;
          end else if (busy) begin
            n.refused = 1'b1;
          end else if (cmd[`PSS_CMD_ACTIVATE_BIT]) begin
            if (slotOk) begin
              n.st = ST_LD_SET;
              n.base = slotBase(s.slot);
              n.keepNow = s.keepIf;
              n.thenMat = 1'b0;
              n.idx = '0;
              n.nvm = '{req: 1'b1, we: 1'b0, addr: slotBase(s.slot), wdata: 32'h00000000};
            end else begin
              n.refused = 1'b1;
            end
          end else if (cmd[`PSS_CMD_SAVE_BIT]) begin
            if (slotOk) begin
              n.st = ST_SV_SET;
              n.base = slotBase(s.slot);
              // Pointer must name this slot even if CTRL changes mid-save
              n.opSlot = s.slot;
              n.idx = '0;
              n.nvm = '{req: 1'b1, we: 1'b1, addr: slotBase(s.slot), wdata: s.liveSet[0]};
            end else begin
              n.refused = 1'b1;
            end
          end else if (cmd[`PSS_CMD_RESTORE_BIT]) begin
            n.idx = '0;
            if (s.matOnly) begin
              n.st = ST_LD_MAT;
              n.base = `PSS_NVM_FAC_MAT;
              n.nvm = '{req: 1'b1, we: 1'b0, addr: `PSS_NVM_FAC_MAT, wdata: 32'h00000000};
            end else begin
              n.st = ST_LD_SET;
              n.base = `PSS_NVM_FAC_SET;
              n.keepNow = s.ifKeep;
              n.thenMat = 1'b1;
              n.matSrc = `PSS_NVM_FAC_MAT;
              n.nvm = '{req: 1'b1, we: 1'b0, addr: `PSS_NVM_FAC_SET, wdata: 32'h00000000};
            end
          end else if (cmd[`PSS_CMD_EXPORT_BIT]) begin
            // Snapshot of the chosen content as one image
            for (int i = 0; i < BUF_WORDS; i++) begin
              if (s.xferSel) begin
                n.xbuf[i] = (i < MAT_WORDS) ? s.liveMat[i] : 32'h00000000;
              end else begin
                n.xbuf[i] = (i < SET_WORDS) ? s.liveSet[i] : 32'h00000000;
              end
            end
            n.xIdx = '0;
          end else if (cmd[`PSS_CMD_IMPORT_BIT]) begin
            // Buffer goes live only here
            for (int i = 0; i < BUF_WORDS; i++) begin
              if (s.xferSel && i < MAT_WORDS) begin
                n.liveMat[i] = s.xbuf[i];
              end else if (!s.xferSel && i < SET_WORDS && !(s.keepIf && i < IF_WORDS)) begin
                n.liveSet[i] = s.xbuf[i];
              end
            end
            n.xIdx = '0;
          end
        end
        default: n.refused = s.refused;
      endcase
    end
    // Memory sequencer, one word per answer
    if (step) begin
      case (s.st)
        ST_BOOT: begin
          if (nvmRsp.rdata[1:0] != 2'h0 && 32'(nvmRsp.rdata) <= `PSS_SLOT_MAX) begin
            n.st = ST_LD_SET;
            n.slot = nvmRsp.rdata[1:0];
            n.lastSlot = nvmRsp.rdata[1:0];
            n.base = slotBase(nvmRsp.rdata[1:0]);
            n.keepNow = 1'b0;
            n.thenMat = 1'b1;
            n.matSrc = `PSS_NVM_MAT_BASE;
            n.idx = '0;
            n.nvm.addr = slotBase(nvmRsp.rdata[1:0]);
          end else begin
            n.st = ST_IDLE;
            n.nvm.req = 1'b0;
          end
        end
        ST_LD_SET: begin
          if (!(s.keepNow && 32'(s.idx) < IF_WORDS)) begin
            n.liveSet[s.idx] = nvmRsp.rdata;
          end
          if (lastSet && s.thenMat) begin
            n.st = ST_LD_MAT;
            n.base = s.matSrc;
            n.idx = '0;
            n.nvm.addr = s.matSrc;
          end else if (lastSet) begin
            n.st = ST_IDLE;
            n.nvm.req = 1'b0;
          end else begin
            n.idx = s.idx + 1'b1;
            n.nvm.addr = s.base + 16'(s.idx) + 16'h0001;
          end
        end
        ST_LD_MAT: begin
          n.liveMat[s.idx] = nvmRsp.rdata;
          if (lastMat) begin
            n.st = ST_IDLE;
            n.nvm.req = 1'b0;
          end else begin
            n.idx = s.idx + 1'b1;
            n.nvm.addr = s.base + 16'(s.idx) + 16'h0001;
          end
        end
        ST_SV_SET: begin
          if (lastSet) begin
            n.st = ST_SV_MAT;
            n.base = `PSS_NVM_MAT_BASE;
            n.idx = '0;
            n.nvm.addr = `PSS_NVM_MAT_BASE;
            n.nvm.wdata = s.liveMat[0];
          end else begin
            n.idx = s.idx + 1'b1;
            n.nvm.addr = s.base + 16'(s.idx) + 16'h0001;
            n.nvm.wdata = s.liveSet[s.idx + 1'b1];
          end
        end
        ST_SV_MAT: begin
          if (lastMat) begin
            n.st = ST_SV_PTR;
            n.nvm.addr = `PSS_NVM_PTR_ADDR;
            n.nvm.wdata = {30'h0, s.opSlot};
          end else begin
            n.idx = s.idx + 1'b1;
            n.nvm.addr = s.base + 16'(s.idx) + 16'h0001;
            n.nvm.wdata = s.liveMat[s.idx + 1'b1];
          end
        end
        ST_SV_PTR: begin
          n.st = ST_IDLE;
          n.lastSlot = s.nvm.wdata[1:0];
          n.nvm = '0;
        end
        default: n.st = ST_IDLE;
      endcase
    end
  end

  // State register
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s <= '0;
      s.st <= ST_BOOT;
      s.slot <= `PSS_SLOT_RST;
      s.nvm.req <= 1'b1;
      s.nvm.addr <= `PSS_NVM_PTR_ADDR;
    end else begin
      s <= n;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  a_boot_pointer: assert property ((s.st == ST_BOOT) |-> s.nvm.req && !s.nvm.we && s.nvm.addr == `PSS_NVM_PTR_ADDR)
    else $error("boot does not read the save pointer");
  a_boot_recall: assert property ((s.st == ST_BOOT && step && nvmRsp.rdata == 32'h2)
    |=> s.st == ST_LD_SET && s.base == slotBase(2'h2) && s.thenMat)
    else $error("boot did not recall the saved slot");
  a_slot_address: assert property ((wrDone && regOff == `PSS_REG_CMD && cmd == 5'h01 && !busy && slotOk)
    |=> s.st == ST_LD_SET && s.nvm.addr == slotBase($past(s.slot)))
    else $error("load does not address the selected slot");
  a_load_word: assert property ((s.st == ST_LD_SET && step && !s.keepNow)
    |=> s.liveSet[$past(s.idx)] == $past(nvmRsp.rdata))
    else $error("loaded word not copied to live settings");
  a_keep_iface: assert property ((s.st == ST_LD_SET && step && s.keepNow && s.idx == '0)
    |=> $stable(s.liveSet[0]))
    else $error("interface word changed under keep flag");
  a_save_data: assert property ((s.st == ST_SV_SET && s.nvm.req)
    |-> s.nvm.we && s.nvm.wdata == s.liveSet[s.idx] && s.nvm.addr == s.base + 16'(s.idx))
    else $error("save writes wrong word");
  a_load_end: assert property ((s.st == ST_LD_MAT && step && lastMat) |=> s.st == ST_IDLE && !s.nvm.req)
    else $error("load did not end in normal operation");
  a_mat_only: assert property ((wrDone && regOff == `PSS_REG_CMD && cmd == 5'h10 && !busy && s.matOnly)
    |=> s.st == ST_LD_MAT && s.nvm.addr == `PSS_NVM_FAC_MAT ##1 $stable(s.liveSet))
    else $error("material-only restore touched other settings");
  a_import_gate: assert property ((wrDone && regOff == `PSS_REG_XFER_DATA && !busy) |=> $stable(s.liveSet) && $stable(s.liveMat))
    else $error("import data applied without command");
  a_export_image: assert property ((wrDone && regOff == `PSS_REG_CMD && cmd == 5'h04 && !busy && !s.xferSel)
    |=> s.xbuf[0] == $past(s.liveSet[0]) && s.xIdx == '0)
    else $error("export image does not match setup");
  a_busy_refuse: assert property ((wrDone && regOff == `PSS_REG_CMD && cmd != 5'h00 && busy)
    |=> s.refused && $stable(s.base))
    else $error("request taken while busy");
  a_bus_answer: assert property ((avs.read || avs.write) |-> ##[0:1] !waitrequest)
    else $error("bus answer later than one wait state");
  // Save start, pointer word, full restore and refused-flag clearing
  a_save_slot: assert property ((wrDone && regOff == `PSS_REG_CMD && cmd == 5'h02 && !busy && slotOk)
    |=> s.st == ST_SV_SET && s.nvm.we && s.nvm.addr == slotBase($past(s.slot)))
    else $error("save does not address the selected slot");
  a_save_pointer: assert property ((s.st == ST_SV_PTR)
    |-> s.nvm.req && s.nvm.we && s.nvm.addr == `PSS_NVM_PTR_ADDR && s.nvm.wdata == {30'h0, s.opSlot})
    else $error("pointer write does not name the saved slot");
  a_restore_full: assert property ((wrDone && regOff == `PSS_REG_CMD && cmd == 5'h10 && !busy && !s.matOnly)
    |=> s.st == ST_LD_SET && s.base == `PSS_NVM_FAC_SET && s.thenMat)
    else $error("full restore does not start from factory setup");
  a_clear_refused: assert property ((wrDone && regOff == `PSS_REG_CMD && cmd == 5'h04 && !busy)
    |=> !s.refused)
    else $error("accepted command left refused flag set");
endmodule

// [pss_parameter_set_store_test.sv]
`timescale 1ns/1ps
`include "pss_map.svh"
module pss_parameter_set_store_test;
  import pss_pkg::*;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic slowMem = 1'b0;
  pss_avs_req_t avs = '0;
  logic [31:0] readdata;
  logic waitrequest;
  logic busy;
  pss_nvm_req_t nvmReq;
  pss_nvm_rsp_t nvmRsp;
  int failures = 0;
  int tests_run = 0;
  int cycles = 0;
  int seed = 63;
  logic [31:0] expQ[$];
  logic [31:0] live[8];
  logic [31:0] sv[8];
  logic [31:0] imp[8];
  pss_parameter_set_store pss_parameter_set_store_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .avs(avs),
    .readdata(readdata), .waitrequest(waitrequest), .nvmReq(nvmReq), .nvmRsp(nvmRsp), .busy(busy));
  pss_nvm_model pss_nvm_model_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .slowMem(slowMem),
    .nvmReq(nvmReq), .nvmRsp(nvmRsp));
  // 40 MHz clock
  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  // One Avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    logic [31:0] r;
    n = 0;
    r = $random(seed);
    @(posedge ref_clk);
    avs <= '{a, !w, w, d};
    slowMem <= r[0];
    @(negedge ref_clk);
    while (waitrequest !== 1'b0 && n < 50) begin
      @(negedge ref_clk);
      n++;
    end
    if (n == 50) failures++;
    @(posedge ref_clk);
    avs <= '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    expQ.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    @(negedge ref_clk);
    while (busy !== 1'b0 && n < 500) begin
      @(negedge ref_clk);
      n++;
    end
    if (n == 500) failures++;
  endtask
  task automatic check_live();
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, `PSS_REG_LIVE_IDX, 32'(i));
      rd(`PSS_REG_LIVE_DATA, live[i]);
    end
  endtask
  // Random words written through an index/data register pair
  task automatic fill(input logic [7:0] ia, input logic [7:0] da, output logic [31:0] v[8]);
    bus(1'b1, ia, 32'h0);
    for (int i = 0; i < 8; i++) begin
      v[i] = $random(seed);
      bus(1'b1, da, v[i]);
    end
  endtask
  task automatic cmd(input logic [31:0] ctrl, input logic [31:0] c);
    bus(1'b1, `PSS_REG_CTRL, ctrl);
    bus(1'b1, `PSS_REG_CMD, c);
  endtask
  // Completed reads against the oldest noted value
  always @(negedge ref_clk) begin
    if (avs.read && waitrequest === 1'b0) begin
      if (expQ.size() == 0) begin
        chk("unexpected read", 32'h0, 32'hFFFFFFFF);
      end else begin
        chk("readdata", expQ.pop_front(), readdata);
      end
    end
  end
  // Hang guard
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      wrap_up();
    end
  end
  // Main sequence
  initial begin
    repeat (10) @(posedge ref_clk);
    sys_rst <= 1'b0;
    wait_idle();
    for (int i = 0; i < 8; i++) begin
      live[i] = 32'h5A000080 | i;
    end
    rd(`PSS_REG_STATUS, 32'h8);
    check_live();
    fill(`PSS_REG_LIVE_IDX, `PSS_REG_LIVE_DATA, live);
    sv = live;
    cmd(32'h3, 32'h2);
    wait_idle();
    for (int i = 0; i < 8; i++) begin
      chk("slot word", live[i], pss_nvm_model_inst.mem[10'h0C0 + i]);
      chk("material word", 32'h5A000100 | i, pss_nvm_model_inst.mem[10'h100 + i]);
    end
    chk("boot pointer", 32'h3, pss_nvm_model_inst.mem[10'h300]);
    rd(`PSS_REG_STATUS, 32'hC);
    fill(`PSS_REG_LIVE_IDX, `PSS_REG_LIVE_DATA, live);
    cmd(32'h7, 32'h1);
    bus(1'b1, `PSS_REG_CMD, 32'h2);
    wait_idle();
    for (int i = 2; i < 8; i++) begin
      live[i] = sv[i];
    end
    check_live();
    rd(`PSS_REG_STATUS, 32'hE);
    bus(1'b1, `PSS_REG_CMD, 32'h4);
    rd(`PSS_REG_STATUS, 32'hC);
    cmd(32'h0, 32'h1);
    @(negedge ref_clk);
    chk("busy", 32'h0, {31'h0, busy});
    rd(`PSS_REG_STATUS, 32'hE);
    cmd(32'h3, 32'h4);
    for (int i = 0; i < 8; i++) begin
      rd(`PSS_REG_XFER_DATA, live[i]);
    end
    cmd(32'hB, 32'h4);
    for (int i = 0; i < 8; i++) begin
      rd(`PSS_REG_XFER_DATA, 32'h5A000100 | i);
    end
    bus(1'b1, `PSS_REG_CTRL, 32'h3);
    fill(`PSS_REG_XFER_IDX, `PSS_REG_XFER_DATA, imp);
    check_live();
    bus(1'b1, `PSS_REG_CMD, 32'h8);
    live = imp;
    check_live();
    cmd(32'h13, 32'h10);
    wait_idle();
    check_live();
    cmd(32'h1B, 32'h4);
    for (int i = 0; i < 8; i++) begin
      rd(`PSS_REG_XFER_DATA, 32'h5A000240 | i);
    end
    cmd(32'h23, 32'h10);
    wait_idle();
    for (int i = 2; i < 8; i++) begin
      live[i] = 32'h5A000200 | i;
    end
    check_live();
    rd(`PSS_REG_CTRL, 32'h23);
    rd(`PSS_REG_CMD, 32'h0);
    bus(1'b1, 8'h1C, 32'hFFFFFFFF);
    rd(8'h1C, 32'h0);
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
    wait_idle();
    live = sv;
    rd(`PSS_REG_STATUS, 32'hC);
    check_live();
    repeat (3) @(posedge ref_clk);
    wrap_up();
  end
endmodule

// [pss_pkg.sv]
package pss_pkg;
  typedef enum logic [2:0] {ST_BOOT, ST_IDLE, ST_LD_SET, ST_LD_MAT, ST_SV_SET, ST_SV_MAT, ST_SV_PTR} pss_state_e;
  typedef struct packed {
    logic [7:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
  } pss_avs_req_t;
  typedef struct packed {
    logic req;
    logic we;
    logic [15:0] addr;
    logic [31:0] wdata;
  } pss_nvm_req_t;
  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
  } pss_nvm_rsp_t;
endpackage
